// >>> verilog/pwm_timer_consts.svh
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define OFS_TIMER_STATUS   12'h000
`define OFS_CNT_HIGH       12'h004
`define OFS_CNT_LOW        12'h008
`define OFS_RELOAD_HIGH    12'h00C
`define OFS_RELOAD_LOW     12'h010
`define OFS_DUTY_HIGH      12'h014
`define OFS_DUTY_LOW       12'h018
`define OFS_PULSE_CONTROL  12'h01C
`define OFS_PULSE_STATUS   12'h020
`define OFS_POWER_MODE     12'h024

// ****************************************
// field positions
// ****************************************
`define BIT_CMP_IE         0
`define BIT_ROLL_IE        1
`define BIT_ROLL_FLAG      2
`define BIT_CK_LO          3
`define BIT_CK_HI          4
`define BIT_OE             0
`define BIT_POL            1
`define BIT_CMPF           0
`define BIT_SLOW           0
`define BIT_HALT           1
`define BIT_AHALT          2
`define BIT_CPU_MASK       3

// ****************************************
// reset values and timing
// ****************************************
`define RST_COUNT          12'h000
`define CNT_MAX            12'hFFF
`define SLOW_DIV           6'h20
`define TB_PERIOD_NS       1000000
`define CLK_PERIOD_NS      5
`define TB_CYCLES          (`TB_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// >>> verilog/pwm_timer_pkg.sv
`default_nettype none
package pwm_timer_pkg;
    typedef enum logic [1:0] {
        CK_OFF  = 2'b00,
        CK_LTIM = 2'b01,
        CK_CPU  = 2'b10,
        CK_RSVD = 2'b11
    } clk_sel_t;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ACCESS = 2'b01
    } bus_state_t;
endpackage : pwm_timer_pkg
`default_nettype wire

// >>> verilog/tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface : tick_if
`default_nettype wire

// >>> verilog/count_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_consts.svh"
module count_tick_gen #(
    parameter int TB_CYCLES = `TB_CYCLES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire pwm_timer_pkg::clk_sel_t clk_sel,
    input  wire logic                  slow_mode,
    input  wire logic                  halted,
    tick_if.source                     tk
);
    typedef struct packed {
        logic [31:0] tb_cnt;
        logic [5:0]  slow_cnt;
        logic        tick;
    } tick_state_t;

    tick_state_t st_ff;
    tick_state_t nxt_st;
    logic        src;
    logic        last;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        // low-speed timebase runs even when unselected
        if (st_ff.tb_cnt == 32'(TB_CYCLES - 1)) begin
            nxt_st.tb_cnt = 32'h0;
        end else begin
            nxt_st.tb_cnt = st_ff.tb_cnt + 32'h1;
        end
        src = 1'b0;
        unique case (clk_sel)
            pwm_timer_pkg::CK_LTIM: src = (st_ff.tb_cnt == 32'h0);
            pwm_timer_pkg::CK_CPU:  src = 1'b1;
            pwm_timer_pkg::CK_OFF,
            pwm_timer_pkg::CK_RSVD: src = 1'b0;
        endcase
        last = (st_ff.slow_cnt == 6'(`SLOW_DIV - 6'h1));
        // slow mode divides input by 32
        if (src && !halted) begin
            if (slow_mode) begin
                nxt_st.slow_cnt = last ? 6'h0 : st_ff.slow_cnt + 6'h1;
                nxt_st.tick = last;
            end else begin
                nxt_st.tick = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tk.tick = st_ff.tick;
endmodule : count_tick_gen
`default_nettype wire

// >>> verilog/autoreload_pwm_compare_timer.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_consts.svh"
module autoreload_pwm_compare_timer #(
    parameter int TB_CYCLES = `TB_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        pulse_output_pin,
    output var  logic        pulse_output_pin_oe_n,
    output var  logic        rollover_irq,
    output var  logic        compare_irq
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [11:0] up_counter;
        logic [11:0] reload_value;
        logic [11:0] duty_value;
        logic [11:0] duty_preload;
        logic [11:0] shadow;
        logic        cmp_locked;
        logic [1:0]  clk_sel;
        logic        rollover_flag;
        logic        rollover_irq_enable;
        logic        compare_irq_enable;
        logic        compare_flag;
        logic        pwm_output_enable;
        logic        polarity;
        logic        raw_pwm;
        logic        slow_mode;
        logic        halt_mode;
        logic        active_halt;
        logic        cpu_mask;
        logic        pin;
        logic        pin_oe_n;
        logic        roll_irq;
        logic        cmp_irq;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } timer_state_t;

    timer_state_t st_ff;
    timer_state_t nxt_st;
    tick_if       tk ();
    logic         halted;
    logic         setup;
    logic         wr;
    logic         rd;
    logic [11:0]  cmp_val;
    logic         overflow;
    logic         match;

    function automatic logic [31:0] byte_rd(input logic [7:0] b);
        byte_rd = {24'h0, b};
    endfunction : byte_rd

    // halt stops, active halt keeps timebase+irq
    assign halted = st_ff.halt_mode
        || (st_ff.active_halt
            && !(st_ff.clk_sel == 2'b01 && st_ff.rollover_irq_enable));

    count_tick_gen #(
        .TB_CYCLES (TB_CYCLES)
    ) u_tick (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_sel   (pwm_timer_pkg::clk_sel_t'(st_ff.clk_sel)),
        .slow_mode (st_ff.slow_mode),
        .halted    (halted),
        .tk        (tk.source)
    );

    assign setup = psel && !penable;
    assign wr    = psel && penable && st_ff.ready && pwrite;
    assign rd    = psel && penable && st_ff.ready && !pwrite;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        cmp_val = st_ff.pwm_output_enable ? st_ff.shadow : st_ff.duty_value;
        overflow = tk.tick && (st_ff.up_counter == `CNT_MAX);
        // zero duty never compares; locked until low byte
        match = tk.tick && !overflow && !st_ff.cmp_locked
            && (cmp_val != 12'h000)
            && (st_ff.up_counter + 12'h1 == cmp_val);

        if (tk.tick) begin
            if (overflow) begin
                nxt_st.up_counter = st_ff.reload_value;
            end else begin
                nxt_st.up_counter = st_ff.up_counter + 12'h1;
            end
        end

        if (overflow) begin
            if (st_ff.pwm_output_enable) begin
                nxt_st.duty_value = st_ff.duty_preload;
                nxt_st.raw_pwm = 1'b1;
            end
            // shadow copy even if low byte unwritten
            nxt_st.shadow = st_ff.pwm_output_enable
                ? st_ff.duty_preload : st_ff.duty_value;
            nxt_st.rollover_flag = 1'b1;
        end
        if (match) begin
            nxt_st.raw_pwm = 1'b0;
            nxt_st.compare_flag = 1'b1;
        end

        // ****************************************
        // apb slave, no wait states
        // ****************************************
        nxt_st.ready  = setup;
        nxt_st.slverr = 1'b0;
        if (setup) begin
            nxt_st.rdata = 32'h0;
            unique case (paddr)
                `OFS_TIMER_STATUS: nxt_st.rdata = byte_rd({3'h0,
                    st_ff.clk_sel, st_ff.rollover_flag,
                    st_ff.rollover_irq_enable, st_ff.compare_irq_enable});
                `OFS_CNT_HIGH:
                    nxt_st.rdata = byte_rd({4'h0, st_ff.up_counter[11:8]});
                `OFS_CNT_LOW:
                    nxt_st.rdata = byte_rd(st_ff.up_counter[7:0]);
                `OFS_RELOAD_HIGH:
                    nxt_st.rdata = byte_rd({4'h0, st_ff.reload_value[11:8]});
                `OFS_RELOAD_LOW:
                    nxt_st.rdata = byte_rd(st_ff.reload_value[7:0]);
                `OFS_DUTY_HIGH:
                    nxt_st.rdata = byte_rd({4'h0, st_ff.duty_preload[11:8]});
                `OFS_DUTY_LOW:
                    nxt_st.rdata = byte_rd(st_ff.duty_preload[7:0]);
                `OFS_PULSE_CONTROL: nxt_st.rdata = byte_rd({6'h0,
                    st_ff.polarity, st_ff.pwm_output_enable});
                `OFS_PULSE_STATUS:
                    nxt_st.rdata = byte_rd({7'h0, st_ff.compare_flag});
                `OFS_POWER_MODE: nxt_st.rdata = byte_rd({4'h0,
                    st_ff.cpu_mask, st_ff.active_halt, st_ff.halt_mode,
                    st_ff.slow_mode});
                default: nxt_st.slverr = 1'b1;
            endcase
            nxt_st.slverr = nxt_st.slverr;
        end
        if (st_ff.ready) begin
            nxt_st.slverr = 1'b0;
        end else begin
            nxt_st.slverr = setup ? nxt_st.slverr : 1'b0;
        end

        // status read clears flag; set wins
        // only a flag that the read returned is cleared, else one
        // raised between setup and access would vanish unseen
        if (rd && paddr == `OFS_TIMER_STATUS && !overflow
            && st_ff.rdata[`BIT_ROLL_FLAG]) begin
            nxt_st.rollover_flag = 1'b0;
        end
        if (rd && paddr == `OFS_PULSE_STATUS && !match
            && st_ff.rdata[`BIT_CMPF]) begin
            nxt_st.compare_flag = 1'b0;
        end

        if (wr) begin
            unique case (paddr)
                `OFS_TIMER_STATUS: begin
                    nxt_st.clk_sel = pwdata[`BIT_CK_HI:`BIT_CK_LO];
                    nxt_st.rollover_irq_enable = pwdata[`BIT_ROLL_IE];
                    nxt_st.compare_irq_enable = pwdata[`BIT_CMP_IE];
                end
                `OFS_RELOAD_HIGH:
                    nxt_st.reload_value[11:8] = pwdata[3:0];
                `OFS_RELOAD_LOW:
                    nxt_st.reload_value[7:0] = pwdata[7:0];
                `OFS_DUTY_HIGH: begin
                    nxt_st.duty_preload[11:8] = pwdata[3:0];
                    nxt_st.cmp_locked = 1'b1;
                    // compare mode takes value at once
                    if (!st_ff.pwm_output_enable) begin
                        nxt_st.duty_value[11:8] = pwdata[3:0];
                    end
                end
                `OFS_DUTY_LOW: begin
                    nxt_st.duty_preload[7:0] = pwdata[7:0];
                    nxt_st.cmp_locked = 1'b0;
                    if (!st_ff.pwm_output_enable) begin
                        nxt_st.duty_value[7:0] = pwdata[7:0];
                    end
                end
                `OFS_PULSE_CONTROL: begin
                    nxt_st.pwm_output_enable = pwdata[`BIT_OE];
                    nxt_st.polarity = pwdata[`BIT_POL];
                end
                `OFS_POWER_MODE: begin
                    nxt_st.slow_mode = pwdata[`BIT_SLOW];
                    nxt_st.halt_mode = pwdata[`BIT_HALT];
                    nxt_st.active_halt = pwdata[`BIT_AHALT];
                    nxt_st.cpu_mask = pwdata[`BIT_CPU_MASK];
                end
                default: ;
            endcase
        end

        nxt_st.pin = nxt_st.pwm_output_enable
            & (nxt_st.raw_pwm ^ nxt_st.polarity);
        nxt_st.pin_oe_n = !nxt_st.pwm_output_enable;
        // separate irq lines, cpu mask gates both
        nxt_st.roll_irq = nxt_st.rollover_flag
            & nxt_st.rollover_irq_enable & !nxt_st.cpu_mask;
        nxt_st.cmp_irq = nxt_st.compare_flag
            & nxt_st.compare_irq_enable & !nxt_st.cpu_mask;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.pin_oe_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata                = st_ff.rdata;
    assign pready                = st_ff.ready;
    assign pslverr               = st_ff.slverr;
    assign pulse_output_pin      = st_ff.pin;
    assign pulse_output_pin_oe_n = st_ff.pin_oe_n;
    assign rollover_irq          = st_ff.roll_irq;
    assign compare_irq           = st_ff.cmp_irq;
endmodule : autoreload_pwm_compare_timer
`default_nettype wire

// >>> test/pwm_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input  wire logic clk,
    input  wire logic pin,
    output var int    high_len,
    output var int    period
);
    // ****************************************
    // pulse width and period of the load pin
    // ****************************************
    int   hi_cnt;
    int   per_cnt;
    logic last;
    initial begin
        hi_cnt = 0;
        per_cnt = 0;
        last = 1'b0;
        high_len = 0;
        period = 0;
    end
    // a plain resistive load: samples only, never drives back
    always @(posedge clk) begin
        last <= pin;
        hi_cnt <= pin ? hi_cnt + 1 : 0;
        if (!pin && last) high_len <= hi_cnt;
        if (pin && !last) begin
            period <= per_cnt;
            per_cnt <= 1;
        end else begin
            per_cnt <= per_cnt + 1;
        end
    end
endmodule : pwm_load_model
`default_nettype wire

// >>> test/autoreload_pwm_compare_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_consts.svh"
module autoreload_pwm_compare_timer_properties #(
    parameter int TB_CYCLES = 8
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pulse_output_pin,
    input wire logic        pulse_output_pin_oe_n,
    input wire logic        rollover_irq,
    input wire logic        compare_irq
);
    // ****************************************
    // bus and pin relations
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ctl_wr;
        psel && penable && pready && pwrite && paddr == `OFS_PULSE_CONTROL;
    endsequence
    property p_answer;
        s_setup |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_refused_zero;
        pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    property p_pin_gated;
        pulse_output_pin_oe_n |-> !pulse_output_pin;
    endproperty
    property p_oe_on;
        s_ctl_wr ##0 pwdata[`BIT_OE] |=> ##[0:1] !pulse_output_pin_oe_n;
    endproperty
    property p_oe_off;
        s_ctl_wr ##0 !pwdata[`BIT_OE] |=> ##[0:1] pulse_output_pin_oe_n;
    endproperty
    a_answer:          assert property (p_answer)
        else $error("no ready in first access cycle");
    a_ready_pulse:     assert property (p_ready_pulse)
        else $error("ready held over two cycles");
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("ready outside access phase");
    a_err_with_ready:  assert property (p_err_with_ready)
        else $error("error without ready");
    a_refused_zero:    assert property (p_refused_zero)
        else $error("refused read returned data");
    a_pin_gated:       assert property (p_pin_gated)
        else $error("pin high while output disabled");
    a_oe_on:           assert property (p_oe_on)
        else $error("output enable not applied");
    a_oe_off:          assert property (p_oe_off)
        else $error("output enable not removed");
endmodule : autoreload_pwm_compare_timer_properties
bind autoreload_pwm_compare_timer autoreload_pwm_compare_timer_properties #(
    .TB_CYCLES(TB_CYCLES)
) i_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pulse_output_pin, .pulse_output_pin_oe_n,
    .rollover_irq, .compare_irq
);
`default_nettype wire

// >>> test/autoreload_pwm_compare_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_consts.svh"
module autoreload_pwm_compare_timer_bench;
    // ****************************************
    // clock, design and load
    // ****************************************
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr, rel, duty;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, pin, oe_n, roll_irq, cmp_irq;
    int          num_errors, checks, high_len, period, per;
    logic [31:0] exp_q[$], msk_q[$], err_q[$];
    always #2.5 pclk = ~pclk;
    autoreload_pwm_compare_timer #(.TB_CYCLES(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_output_pin(pin),
        .pulse_output_pin_oe_n(oe_n), .rollover_irq(roll_irq),
        .compare_irq(cmp_irq));
    pwm_load_model i_load (.clk(pclk), .pin(pin), .high_len(high_len),
        .period(period));
    task final_report;
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task check_val(input string nm, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : check_val
    task check_rd(input logic [31:0] e, m, s);
        check_val("prdata", e & m, s & m);
    endtask : check_rd
    // ****************************************
    // apb master; holds request until ready
    // ****************************************
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin num_errors++; final_report(); end
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        // map is contiguous words from status up to power mode
        err_q.push_back({31'h0, a > `OFS_POWER_MODE || a[1:0] != 2'b00});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task idle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : idle
    // interrupt lines are levels; wait bounded, timeout is a mismatch
    task wait_for(input bit cmp, input int lim);
        int n;
        n = 0;
        @(negedge pclk);
        while ((cmp ? cmp_irq : roll_irq) !== 1'b1 && n < lim) begin
            @(negedge pclk);
            n++;
        end
        checks++;
        if (n >= lim) begin num_errors++; final_report(); end
    endtask : wait_for
    // read data and error taken at the edge that samples pready
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check_rd(exp_q.pop_front(), msk_q.pop_front(), prdata);
            check_val("pslverr", err_q.pop_front(), {31'h0, pslverr});
        end
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; num_errors = 0; checks = 0;
        void'($urandom(32'hCEC559E3));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_CNT_LOW, 32'h0, 32'hFF);
        rd(`OFS_CNT_HIGH, 32'h0, 32'hF);
        rd(12'h0FC, 32'h0, 32'hFFFFFFFF);
        // ****************************************
        // pwm mode, random short period
        // ****************************************
        // reload kept below 4095
        rel = 12'hFF0 + 12'($urandom % 8);
        per = 4096 - int'(rel);
        duty = rel + 12'h001 + 12'($urandom % (per - 1));
        wr(`OFS_RELOAD_HIGH, {28'h0, rel[11:8]});
        wr(`OFS_RELOAD_LOW, {24'h0, rel[7:0]});
        rd(`OFS_RELOAD_LOW, {24'h0, rel[7:0]}, 32'hFF);
        wr(`OFS_DUTY_HIGH, {28'h0, duty[11:8]});
        wr(`OFS_DUTY_LOW, {24'h0, duty[7:0]});
        wr(`OFS_PULSE_CONTROL, 32'h1);
        wr(`OFS_TIMER_STATUS, 32'h13);
        // first rollover needs a full count from zero
        wait_for(1'b0, 5000);
        idle(3 * per);
        check_val("period", per, period);
        check_val("high", int'(duty - rel), high_len);
        wr(`OFS_PULSE_CONTROL, 32'h3);
        idle(3 * per);
        check_val("high_inv", per - int'(duty - rel), high_len);
        wr(`OFS_POWER_MODE, 32'h1);
        idle(3 * 32 * per);
        check_val("period_slow", 32 * per, period);
        wr(`OFS_POWER_MODE, 32'h8);
        idle(2);
        check_val("roll_masked", 32'h0, roll_irq);
        wr(`OFS_POWER_MODE, 32'h0);
        // ****************************************
        // output compare mode
        // ****************************************
        // enable cleared for compare mode
        wr(`OFS_PULSE_CONTROL, 32'h0);
        // matches in pwm mode have left the compare flag set
        rd(`OFS_PULSE_STATUS, 32'h1, 32'h1);
        duty = rel + 12'h002;
        wr(`OFS_DUTY_HIGH, {28'h0, duty[11:8]});
        wr(`OFS_DUTY_LOW, {24'h0, duty[7:0]});
        wait_for(1'b1, per + 8);
        rd(`OFS_PULSE_STATUS, 32'h1, 32'h1);
        rd(`OFS_TIMER_STATUS, 32'h4, 32'h4);
        wr(`OFS_DUTY_HIGH, 32'h0);
        wr(`OFS_DUTY_LOW, 32'h0);
        rd(`OFS_PULSE_STATUS, 32'h0, 32'h0);
        idle(2 * per);
        check_val("cmp_zero", 32'h0, cmp_irq);
        wr(`OFS_TIMER_STATUS, 32'h2);
        rd(`OFS_TIMER_STATUS, 32'h0, 32'h0);
        rd(`OFS_TIMER_STATUS, 32'h2, 32'h1F);
        idle(1);
        check_val("roll_clear", 32'h0, roll_irq);
        final_report();
    end
endmodule : autoreload_pwm_compare_timer_bench
`default_nettype wire
